// ### logic/gtm_params.svh
// constants of the guard timer: addresses, keys, fields, reset values, timing
`ifndef GTM_PARAMS_SVH
`define GTM_PARAMS_SVH
`define GTM_ADDR_CTRL_WR    16'hFFA4
`define GTM_ADDR_RST_WR     16'hFFA6
`define GTM_ADDR_CTRL_RD    16'hFFA4
`define GTM_ADDR_CNT_RD     16'hFFA5
`define GTM_ADDR_RST_RD     16'hFFA7
`define GTM_KEY_A           8'h5A
`define GTM_KEY_B           8'hA5
`define GTM_ZERO_BYTE       8'h00
`define GTM_BIT_IOVF        7
`define GTM_BIT_MODE        6
`define GTM_BIT_CEN         5
`define GTM_BIT_CRE         6
`define GTM_BIT_WATCHDOG_OVERFLOW_FLAG        7
`define GTM_CTRL_FIXED      8'h18
`define GTM_RST_FIXED       8'h1F
`define GTM_CNT_MAX         8'hFF
`define GTM_PULSE_CYCLES    519
`define GTM_PRESC_W         17
`define GTM_TAP_SEL0        0
`define GTM_TAP_SEL1        5
`define GTM_TAP_SEL2        6
`define GTM_TAP_SEL3        8
`define GTM_TAP_SEL4        10
`define GTM_TAP_SEL5        12
`define GTM_TAP_SEL6        14
`define GTM_TAP_SEL7        16
`endif

// ### logic/gtm_pkg.sv
// types of the guard timer
package gtm_pkg;
   typedef enum logic [1:0] {
      GTM_IDLE  = 2'b01,
      GTM_PULSE = 2'b10
   } gtm_rst_state_t;
endpackage

// ### logic/gtm_prescaler.sv
// prescaler, held at zero while run is low, that produces one tick per selected division
`timescale 1ns/1ps
`include "gtm_params.svh"
module gtm_prescaler
   import gtm_pkg::*;
#(
   parameter int PW = `GTM_PRESC_W
) (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        run,
   input  wire logic [2:0]  clockSel,
   output logic             tick
);
   logic [PW-1:0] count;
   logic [PW-1:0] next_count;
   logic          next_tick;

   // tap position for each code, fastest to slowest
   function automatic int tapOf(input logic [2:0] sel);
      case (sel)
         3'h0:    tapOf = `GTM_TAP_SEL0;
         3'h1:    tapOf = `GTM_TAP_SEL1;
         3'h2:    tapOf = `GTM_TAP_SEL2;
         3'h3:    tapOf = `GTM_TAP_SEL3;
         3'h4:    tapOf = `GTM_TAP_SEL4;
         3'h5:    tapOf = `GTM_TAP_SEL5;
         3'h6:    tapOf = `GTM_TAP_SEL6;
         default: tapOf = `GTM_TAP_SEL7;
      endcase
   endfunction

   always_comb begin
      next_count = run ? count + 1'b1 : '0;
      next_tick  = 1'b0;
      if (run && (count[tapOf(clockSel)] == 1'b1) &&
          (next_count[tapOf(clockSel)] == 1'b0)) begin
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule

// ### logic/gtm_guard_timer.sv
// 8-bit guard timer with watchdog and interval modes and keyed word writes
`timescale 1ns/1ps
`include "gtm_params.svh"
// Function
// - mode_select=1 and count_enable=1 runs watchdog mode.
// - watchdog overflow sets watchdog_overflow_flag.
// - watchdog overflow with chip_reset_enable issues internal chip reset.
// - pin reset with coincident overflow wins; watchdog flag stays clear.
// - internal reset pulse lasts exactly 519 clock cycles.
// - internal reset also restores system clock control defaults.
// - chip_reset_enable clear: no chip reset, clock control untouched.
// - mode_select=0 and count_enable=1 runs interval mode.
// - interval overflow sets interval flag and raises interrupt together.
// - only word writes modify counter, control and reset control.
// - shared write address; key 5A writes counter, A5 writes control.
// - reset control write with A5 and 00 clears watchdog flag only.
// - reset control write with 5A copies bit 6 into chip_reset_enable.
// - reads: control, counter and reset control at own byte addresses.
// - counter write coinciding with a tick wins; tick is dropped.
// - watchdog running blocks software standby; sleep is used instead.
// - interval running lets software standby proceed.
// - clearing count_enable stops and zeroes the counter.
// - clock select picks one of eight prescaled tick rates.
// - flags cleared by read while 1 then writing 0; a watchdog overflow also clears the interval flag.
// - watchdog overflow without chip reset still resets counter and control.
module gtm_guard_timer
   import gtm_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        busWrite,
   input  wire logic        busRead,
   input  wire logic        busWord,
   input  wire logic [15:0] busAddr,
   input  wire logic [15:0] busWrData,
   input  wire logic        standbyRequest,
   output logic      [7:0]  busRdData,
   output logic             intervalInterrupt,
   output logic             chipResetOut,
   output logic             clockControlReset,
   output logic             enterStandby
);
   logic [7:0]     tickCounter;
   logic           modeSelect;
   logic           countEnable;
   logic [2:0]     clockSel;
   logic           intervalFlag;
   logic           watchdogFlag;
   logic           chipResetEnable;
   logic           intervalSeen;
   logic           watchdogSeen;
   logic [9:0]     pulseCount;
   gtm_rst_state_t rstState;
   logic           tick;

   logic [7:0]     next_tickCounter;
   logic           next_modeSelect;
   logic           next_countEnable;
   logic [2:0]     next_clockSel;
   logic           next_intervalFlag;
   logic           next_watchdogFlag;
   logic           next_chipResetEnable;
   logic           next_intervalSeen;
   logic           next_watchdogSeen;
   logic [9:0]     next_pulseCount;
   gtm_rst_state_t next_rstState;
   logic [7:0]     next_busRdData;
   logic           next_intervalInterrupt;
   logic           next_chipResetOut;
   logic           next_enterStandby;

   logic           wrCounter;
   logic           wrControl;
   logic           wrRstKeyA;
   logic           wrRstKeyB;
   logic           overflow;
   logic [7:0]     ctrlView;
   logic [7:0]     rstView;

   gtm_prescaler #(.PW(`GTM_PRESC_W)) u_prescaler (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .run      (countEnable),
      .clockSel (clockSel),
      .tick     (tick)
   );

   // word writes only; byte writes are ignored
   always_comb begin
      wrCounter = busWrite && busWord && busAddr == `GTM_ADDR_CTRL_WR &&
                  busWrData[15:8] == `GTM_KEY_A;
      wrControl = busWrite && busWord && busAddr == `GTM_ADDR_CTRL_WR &&
                  busWrData[15:8] == `GTM_KEY_B;
      wrRstKeyA = busWrite && busWord && busAddr == `GTM_ADDR_RST_WR &&
                  busWrData[15:8] == `GTM_KEY_A;
      wrRstKeyB = busWrite && busWord && busAddr == `GTM_ADDR_RST_WR &&
                  busWrData[15:8] == `GTM_KEY_B &&
                  busWrData[7:0] == `GTM_ZERO_BYTE;
      overflow  = countEnable && tick && !wrCounter &&
                  tickCounter == `GTM_CNT_MAX;
      ctrlView  = `GTM_CTRL_FIXED;
      ctrlView[`GTM_BIT_IOVF] = intervalFlag;
      ctrlView[`GTM_BIT_MODE] = modeSelect;
      ctrlView[`GTM_BIT_CEN]  = countEnable;
      ctrlView[2:0]           = clockSel;
      rstView   = `GTM_RST_FIXED;
      rstView[`GTM_BIT_WATCHDOG_OVERFLOW_FLAG]  = watchdogFlag;
      rstView[`GTM_BIT_CRE]   = chipResetEnable;
   end

   always_comb begin
      next_tickCounter     = tickCounter;
      next_modeSelect      = modeSelect;
      next_countEnable     = countEnable;
      next_clockSel        = clockSel;
      next_intervalFlag    = intervalFlag;
      next_watchdogFlag    = watchdogFlag;
      next_chipResetEnable = chipResetEnable;
      next_intervalSeen    = intervalSeen;
      next_watchdogSeen    = watchdogSeen;
      next_pulseCount      = pulseCount;
      next_rstState        = rstState;
      next_busRdData       = busRdData;

      // reads; reading a set flag arms its clear
      if (busRead) begin
         case (busAddr)
            `GTM_ADDR_CTRL_RD: begin
               next_busRdData = ctrlView;
               if (intervalFlag) next_intervalSeen = 1'b1;
            end
            `GTM_ADDR_CNT_RD:  next_busRdData = tickCounter;
            `GTM_ADDR_RST_RD: begin
               next_busRdData = rstView;
               if (watchdogFlag) next_watchdogSeen = 1'b1;
            end
            default:           next_busRdData = `GTM_ZERO_BYTE;
         endcase
      end

      // counting; a write in the same cycle beats the tick
      if (wrCounter) begin
         next_tickCounter = busWrData[7:0];
      end else if (countEnable && tick) begin
         next_tickCounter = tickCounter + 8'h01;
      end

      if (wrControl) begin
         if (intervalSeen && !busWrData[`GTM_BIT_IOVF]) begin
            next_intervalFlag = 1'b0;
            next_intervalSeen = 1'b0;
         end
         next_modeSelect  = busWrData[`GTM_BIT_MODE];
         next_countEnable = busWrData[`GTM_BIT_CEN];
         next_clockSel    = busWrData[2:0];
         if (!busWrData[`GTM_BIT_CEN]) next_tickCounter = 8'h00;
      end else if (!countEnable) begin
         next_tickCounter = 8'h00;
      end

      if (wrRstKeyA) next_chipResetEnable = busWrData[`GTM_BIT_CRE];
      if (wrRstKeyB && watchdogSeen) begin
         next_watchdogFlag = 1'b0;
         next_watchdogSeen = 1'b0;
      end

      // overflow sets win over clears
      if (overflow && !modeSelect) next_intervalFlag = 1'b1;
      if (overflow && modeSelect) begin
         next_watchdogFlag = 1'b1;
         next_tickCounter  = 8'h00;
         next_modeSelect   = 1'b0;
         next_countEnable  = 1'b0;
         next_clockSel     = 3'h0;
         next_intervalFlag = 1'b0;
         if (chipResetEnable) begin
            next_rstState   = GTM_PULSE;
            next_pulseCount = 10'h000;
         end
      end

      case (rstState)
         GTM_IDLE: ;
         GTM_PULSE: begin
            if (pulseCount == 10'(`GTM_PULSE_CYCLES - 1)) begin
               next_rstState = GTM_IDLE;
            end else begin
               next_pulseCount = pulseCount + 10'h001;
            end
         end
         default: next_rstState = GTM_IDLE;
      endcase

      next_intervalInterrupt = next_intervalFlag;
      next_chipResetOut      = next_rstState == GTM_PULSE;
      // watchdog running forces sleep instead of standby
      next_enterStandby = standbyRequest && !(next_countEnable && next_modeSelect);
   end

   // pin reset clears everything, so a coincident overflow leaves the flag clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCounter       <= 8'h00;
         modeSelect        <= 1'b0;
         countEnable       <= 1'b0;
         clockSel          <= 3'h0;
         intervalFlag      <= 1'b0;
         watchdogFlag      <= 1'b0;
         chipResetEnable   <= 1'b0;
         intervalSeen      <= 1'b0;
         watchdogSeen      <= 1'b0;
         pulseCount        <= 10'h000;
         rstState          <= GTM_IDLE;
         busRdData         <= 8'h00;
         intervalInterrupt <= 1'b0;
         chipResetOut      <= 1'b0;
         clockControlReset <= 1'b0;
         enterStandby      <= 1'b0;
      end else begin
         tickCounter       <= next_tickCounter;
         modeSelect        <= next_modeSelect;
         countEnable       <= next_countEnable;
         clockSel          <= next_clockSel;
         intervalFlag      <= next_intervalFlag;
         watchdogFlag      <= next_watchdogFlag;
         chipResetEnable   <= next_chipResetEnable;
         intervalSeen      <= next_intervalSeen;
         watchdogSeen      <= next_watchdogSeen;
         pulseCount        <= next_pulseCount;
         rstState          <= next_rstState;
         busRdData         <= next_busRdData;
         intervalInterrupt <= next_intervalInterrupt;
         chipResetOut      <= next_chipResetOut;
         clockControlReset <= next_chipResetOut;
         enterStandby      <= next_enterStandby;
      end
   end

   // pulse width counter for assertions
   logic [10:0] pulseLen;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) pulseLen <= 11'h000;
      else if (chipResetOut) pulseLen <= pulseLen + 11'h001;
      else pulseLen <= 11'h000;
   end

   sequence s_wdOverflow;
      overflow && modeSelect && chipResetEnable;
   endsequence
   sequence s_pulseStart;
      ##1 rstState == GTM_PULSE ##1 chipResetOut;
   endsequence
   sequence s_pulseHold;
      chipResetOut [*8];
   endsequence

   a_wd_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      overflow && modeSelect |=> watchdogFlag)
      else $error("watchdog flag not set on overflow");

   a_wd_flag_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(watchdogFlag) |-> $past(modeSelect))
      else $error("watchdog flag set outside watchdog mode");

   a_chip_reset_start: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_wdOverflow |-> s_pulseStart)
      else $error("chip reset did not start");

   a_pulse_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(chipResetOut) |-> s_pulseHold)
      else $error("reset pulse ended early");

   a_pulse_width: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(chipResetOut) |-> pulseLen == 11'(`GTM_PULSE_CYCLES))
      else $error("reset pulse width wrong");

   a_pulse_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
      pulseLen <= 11'(`GTM_PULSE_CYCLES))
      else $error("reset pulse too long");

   a_clock_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
      clockControlReset == chipResetOut)
      else $error("clock control reset differs from chip reset");

   a_no_reset_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      overflow && modeSelect && !chipResetEnable && !chipResetOut |=> ##1 !chipResetOut)
      else $error("chip reset without enable");

   a_irq_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      overflow && !modeSelect |=> intervalInterrupt && intervalFlag)
      else $error("interval interrupt missing");

   a_irq_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
      intervalInterrupt == intervalFlag)
      else $error("interrupt differs from interval flag");

   a_byte_ignored: assert property (@(posedge core_clk) disable iff (sys_rst)
      busWrite && !busWord && !countEnable |=> $stable(chipResetEnable))
      else $error("byte write changed register");

   a_ctrl_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      wrControl && !overflow |=> modeSelect == $past(busWrData[`GTM_BIT_MODE]) &&
      countEnable == $past(busWrData[`GTM_BIT_CEN]))
      else $error("control write lost");

   a_wflag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      wrRstKeyB && watchdogSeen && !(overflow && modeSelect) |=>
      !watchdogFlag && $stable(chipResetEnable))
      else $error("watchdog flag clear failed");

   a_cre_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
      wrRstKeyA && !(overflow && modeSelect) |=>
      chipResetEnable == $past(busWrData[`GTM_BIT_CRE]) && $stable(watchdogFlag))
      else $error("reset enable write wrong");

   a_cnt_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      busRead && busAddr == `GTM_ADDR_CNT_RD |=> busRdData == $past(tickCounter))
      else $error("counter read wrong");

   a_cnt_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      wrCounter && countEnable && !wrControl |=> tickCounter == $past(busWrData[7:0]))
      else $error("counter write lost");

   a_standby_block: assert property (@(posedge core_clk) disable iff (sys_rst)
      countEnable && modeSelect |-> !enterStandby)
      else $error("standby entered in watchdog mode");

   a_standby_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
      standbyRequest && !next_modeSelect |=> enterStandby)
      else $error("standby refused outside watchdog mode");

   a_stop_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      !countEnable && !wrCounter && !wrControl |=> tickCounter == 8'h00)
      else $error("stopped counter not zero");

   a_iflag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(intervalFlag) |-> $past(intervalSeen) || $past(modeSelect))
      else $error("interval flag cleared without read");

   a_wflag_seen: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(watchdogFlag) |-> $past(watchdogSeen))
      else $error("watchdog flag cleared without read");

   a_wd_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
      overflow && modeSelect |=> !countEnable && tickCounter == 8'h00)
      else $error("overflow did not reset timer");

   a_count_up: assert property (@(posedge core_clk) disable iff (sys_rst)
      countEnable && tick && !wrCounter && !wrControl && !overflow |=>
      tickCounter == $past(tickCounter) + 8'h01)
      else $error("counter did not step");

   a_wrap_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      overflow && !modeSelect && !wrControl |=> tickCounter == 8'h00)
      else $error("counter did not wrap to zero");
endmodule

// ### tb/gtm_cpu_model.sv
// processor side model that drives the guard timer bus
`timescale 1ns/1ps
module gtm_cpu_model (
   input  wire logic        core_clk,
   input  wire logic [7:0]  busRdData,
   output logic             busWrite,
   output logic             busRead,
   output logic             busWord,
   output logic [15:0]      busAddr,
   output logic [15:0]      busWrData
);
   initial begin
      busWrite = 1'b0;
      busRead = 1'b0;
      busWord = 1'b0;
      busAddr = 16'h0000;
      busWrData = 16'h0000;
   end

   // key byte in the upper half, data byte in the lower half
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
      @(negedge core_clk);
      busAddr = a;
      busWrData = d;
      busWord = w;
      busWrite = 1'b1;
      @(negedge core_clk);
      busWrite = 1'b0;
      busWrData = ~d;
   endtask

   // read data is registered at the taking edge and sampled one half cycle later
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      @(negedge core_clk);
      busAddr = a;
      busRead = 1'b1;
      @(negedge core_clk);
      busRead = 1'b0;
      q = busRdData;
   endtask
endmodule

// ### tb/watchdog_interval_timer_tb.sv
// self-checking bench for the guard timer
`timescale 1ns/1ps
`include "gtm_params.svh"
module watchdog_interval_timer_tb;
   import gtm_pkg::*;
   localparam logic [15:0] ctrlAddr = `GTM_ADDR_CTRL_WR;
   localparam logic [15:0] cntAddr  = `GTM_ADDR_CNT_RD;
   localparam logic [15:0] rstWr    = `GTM_ADDR_RST_WR;
   localparam logic [15:0] rstAddr  = `GTM_ADDR_RST_RD;
   logic        core_clk;
   logic        sys_rst;
   logic        busWrite;
   logic        busRead;
   logic        busWord;
   logic [15:0] busAddr;
   logic [15:0] busWrData;
   logic        standbyRequest;
   logic [7:0]  busRdData;
   logic        intervalInterrupt;
   logic        chipResetOut;
   logic        clockControlReset;
   logic        enterStandby;
   int          n_fail = 0;
   int          n_checks = 0;

   gtm_guard_timer dut (.core_clk(core_clk), .sys_rst(sys_rst), .busWrite(busWrite),
      .busRead(busRead), .busWord(busWord), .busAddr(busAddr), .busWrData(busWrData),
      .standbyRequest(standbyRequest), .busRdData(busRdData),
      .intervalInterrupt(intervalInterrupt), .chipResetOut(chipResetOut),
      .clockControlReset(clockControlReset), .enterStandby(enterStandby));
   gtm_cpu_model cpu (.core_clk(core_clk), .busRdData(busRdData), .busWrite(busWrite),
      .busRead(busRead), .busWord(busWord), .busAddr(busAddr), .busWrData(busWrData));

   always #2 core_clk = ~core_clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chkByte(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkBit(input string nm, input logic e, input logic g);
      chkByte(nm, {7'h00, e}, {7'h00, g});
   endtask

   task automatic chkCount(input string nm, input int e, input int g);
      n_checks++;
      if (g != e) begin
         n_fail++;
         $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      cpu.rd(a, q);
      chkByte($sformatf("read %h", a), e, q);
   endtask

   // k 0 waits for the interrupt, k 1 for the chip reset
   task automatic waitFor(input int k, input int n);
      for (int i = 0; i < n && (k == 0 ? intervalInterrupt : chipResetOut) !== 1'b1; i++)
         @(negedge core_clk);
      chkBit("awaited output", 1'b1, k == 0 ? intervalInterrupt : chipResetOut);
   endtask

   task automatic pinReset();
      sys_rst = 1'b1;
      repeat (3) @(negedge core_clk);
      sys_rst = 1'b0;
   endtask

   task automatic resetValues();
      rdChk(ctrlAddr, 8'h18);
      rdChk(cntAddr, 8'h00);
      rdChk(rstAddr, 8'h1F);
      rdChk(rstWr, 8'h00);
   endtask

   task automatic refusedWrites();
      cpu.wr(ctrlAddr, 16'hA527, 1'b0);
      rdChk(ctrlAddr, 8'h18);
      cpu.wr(ctrlAddr, 16'h3C27, 1'b1);
      rdChk(ctrlAddr, 8'h18);
      cpu.wr(rstWr, 16'h5A40, 1'b0);
      rdChk(rstAddr, 8'h1F);
   endtask

   task automatic counterAccess();
      cpu.wr(ctrlAddr, 16'hA527, 1'b1);
      rdChk(ctrlAddr, 8'h3F);
      cpu.wr(ctrlAddr, 16'h5A37, 1'b1);
      rdChk(cntAddr, 8'h37);
      cpu.wr(ctrlAddr, 16'hA507, 1'b1);
      rdChk(cntAddr, 8'h00);
   endtask

   task automatic intervalRun();
      cpu.wr(ctrlAddr, 16'hA520, 1'b1);
      cpu.wr(ctrlAddr, 16'h5AFE, 1'b1);
      standbyRequest = 1'b1;
      waitFor(0, 40);
      chkBit("standby", 1'b1, enterStandby);
      rdChk(ctrlAddr, 8'hB8);
      cpu.wr(ctrlAddr, 16'hA520, 1'b1);
      @(negedge core_clk);
      chkBit("interrupt", 1'b0, intervalInterrupt);
      cpu.wr(ctrlAddr, 16'hA500, 1'b1);
      standbyRequest = 1'b0;
   endtask

   // code 1 fires near 128 cycles, code 2 near 256 cycles after the start
   task automatic clockSelect();
      cpu.wr(ctrlAddr, 16'hA521, 1'b1);
      cpu.wr(ctrlAddr, 16'h5AFE, 1'b1);
      repeat (20) @(negedge core_clk);
      chkBit("slow tick", 1'b0, intervalInterrupt);
      waitFor(0, 300);
      cpu.wr(ctrlAddr, 16'hA501, 1'b1);
      rdChk(ctrlAddr, 8'h99);
      cpu.wr(ctrlAddr, 16'hA500, 1'b1);
      rdChk(ctrlAddr, 8'h18);
      cpu.wr(ctrlAddr, 16'hA522, 1'b1);
      cpu.wr(ctrlAddr, 16'h5AFE, 1'b1);
      repeat (180) @(negedge core_clk);
      chkBit("div128 early", 1'b0, intervalInterrupt);
      waitFor(0, 200);
      cpu.wr(ctrlAddr, 16'hA502, 1'b1);
      rdChk(ctrlAddr, 8'h9A);
      cpu.wr(ctrlAddr, 16'hA500, 1'b1);
      rdChk(ctrlAddr, 8'h18);
   endtask

   task automatic watchdogNoReset();
      cpu.wr(ctrlAddr, 16'hA560, 1'b1);
      standbyRequest = 1'b1;
      cpu.wr(ctrlAddr, 16'h5AFE, 1'b1);
      chkBit("standby", 1'b0, enterStandby);
      standbyRequest = 1'b0;
      repeat (40) @(negedge core_clk);
      chkBit("chip reset", 1'b0, chipResetOut);
      chkBit("clock reset", 1'b0, clockControlReset);
      rdChk(rstAddr, 8'h9F);
      rdChk(ctrlAddr, 8'h18);
      rdChk(cntAddr, 8'h00);
      cpu.wr(rstWr, 16'hA500, 1'b1);
      rdChk(rstAddr, 8'h1F);
   endtask

   task automatic watchdogReset();
      int nChip;
      int nClk;
      nChip = 0;
      nClk = 0;
      cpu.wr(rstWr, 16'h5A40, 1'b1);
      rdChk(rstAddr, 8'h5F);
      cpu.wr(ctrlAddr, 16'hA560, 1'b1);
      cpu.wr(ctrlAddr, 16'h5AFE, 1'b1);
      waitFor(1, 40);
      for (int i = 0; i < 600 && (chipResetOut || clockControlReset); i++) begin
         nChip += int'(chipResetOut);
         nClk += int'(clockControlReset);
         @(negedge core_clk);
      end
      chkCount("chip reset cycles", `GTM_PULSE_CYCLES, nChip);
      chkCount("clock reset cycles", `GTM_PULSE_CYCLES, nClk);
      rdChk(rstAddr, 8'hDF);
      cpu.wr(rstWr, 16'h5A40, 1'b1);
      rdChk(rstAddr, 8'hDF);
      rdChk(ctrlAddr, 8'h18);
      cpu.wr(rstWr, 16'hA500, 1'b1);
      rdChk(rstAddr, 8'h5F);
   endtask

   task automatic pinResetWins();
      cpu.wr(ctrlAddr, 16'hA560, 1'b1);
      cpu.wr(ctrlAddr, 16'h5AFE, 1'b1);
      waitFor(1, 40);
      pinReset();
      chkBit("chip reset", 1'b0, chipResetOut);
      rdChk(rstAddr, 8'h1F);
   endtask

   initial begin
      core_clk = 1'b0;
      standbyRequest = 1'b0;
      pinReset();
      resetValues();
      refusedWrites();
      counterAccess();
      intervalRun();
      clockSelect();
      watchdogNoReset();
      watchdogReset();
      pinResetWins();
      end_sim();
   end

   // the sequence needs about 1100 cycles; allow 5000
   initial begin
      #20000;
      n_fail++;
      end_sim();
   end
endmodule
